/* File: hdl/ebps_cfg.svh */
// Constants of the external bus port address, select and strobe block
`ifndef EBPS_CFG_SVH
`define EBPS_CFG_SVH
// Pin widths
`define EBPS_ADDR_W 24
`define EBPS_UPPER_W 32
`define EBPS_BYTE_W 8
`define EBPS_WORD_W 48
`define EBPS_BANKS 4
`define EBPS_CORE_ADDR_W 28
// Bank decode: 16M words per plain bank, 64M words per SDRAM bank
`define EBPS_BANK_LSB_PLAIN 24
`define EBPS_BANK_LSB_SDRAM 26
// Peer register window seen on the address pins
`define EBPS_IOP_SPAN 24'h000200
// Packing field value for full width, unpacked fetch
`define EBPS_PACK_FULL 2'h1
// All selects idle
`define EBPS_SEL_IDLE 4'hF
// Least strobe width before acknowledge is honoured
`define EBPS_CLK_PERIOD_NS 8
`define EBPS_STROBE_MIN_NS 16
`define EBPS_STROBE_CYC \
	((`EBPS_STROBE_MIN_NS + `EBPS_CLK_PERIOD_NS - 1) / `EBPS_CLK_PERIOD_NS)
// Extra strobe cycles so synchronised acknowledge and data are fresh
`define EBPS_SYNC_LAG 2
`define EBPS_STROBE_LAST (`EBPS_STROBE_CYC - 1 + `EBPS_SYNC_LAG)
`endif

/* File: hdl/ebps_pkg.sv */
// Types of the external bus port address, select and strobe block
package ebps_pkg;
	// Request from the core for one external word
	typedef struct packed {
		logic write;
		logic fetch;
		logic peer;
		logic sync;
		logic sdram;
		logic [27:0] addr;
		logic [47:0] wdata;
	} ebps_req_t;

	// Access by an outside master to the local peripheral registers
	typedef struct packed {
		logic write;
		logic [23:0] addr;
		logic [47:0] wdata;
	} ebps_slv_t;

	// Master sequence
	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_STROBE = 4'b0010,
		M_WAIT = 4'b0100,
		M_HOLD = 4'b1000
	} ebps_mst_t;

	// Slave sequence
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_BUSY = 3'b010,
		S_END = 3'b100
	} ebps_slv_st_t;
endpackage

/* File: hdl/ebps_pin_sync.sv */
// Three-stage pin synchroniser that passes a value once stages agree
`timescale 1ns/10ps
`default_nettype none
module ebps_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Raw pin and filtered result
	input wire logic [W-1:0] pin,
	output logic [W-1:0] stable
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Stage one is read only by stage two, against metastability
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Each bit moves only when the last two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					stable[i] <= INIT[i];
				end else if (s2_q[i] == s3_q[i]) begin
					stable[i] <= s3_q[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: hdl/ebps_port.sv */
// External bus port: address, data, bank selects and read/write strobes
`include "ebps_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ebps_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Core request port
	input wire logic req_valid,
	input wire ebps_pkg::ebps_req_t req,
	output logic req_ready,
	output logic req_refused,
	output logic rsp_valid,
	output logic [47:0] rsp_rdata,
	// Configuration levels
	input wire logic [1:0] instr_pack_field,
	input wire logic link_ports_off,
	input wire logic bus_master,
	// Outside access to the local peripheral registers
	output logic slv_valid,
	output ebps_pkg::ebps_slv_t slv_req,
	input wire logic slv_done,
	input wire logic [47:0] slv_rdata,
	output logic slv_conflict,
	output logic [3:0] bank_seen,
	// Address pins
	input wire logic [23:0] ext_address_bus_i,
	output logic [23:0] ext_address_bus_o,
	output logic ext_address_bus_oe,
	// Data pins, upper, mid and low lanes
	input wire logic [47:0] ext_data_bus_i,
	output logic [47:0] ext_data_bus_o,
	output logic ext_data_bus_upper_oe,
	output logic ext_data_bus_mid_oe,
	output logic ext_data_bus_low_oe,
	// Bank selects
	input wire logic [3:0] bank_select_n_i,
	output logic [3:0] bank_select_n_o,
	output logic bank_select_n_oe,
	// Strobes and acknowledge
	input wire logic rd_n_i,
	output logic rd_n_o,
	output logic rd_n_oe,
	input wire logic wr_n_i,
	output logic wr_n_o,
	output logic wr_n_oe,
	input wire logic ack_i,
	output logic ack_o,
	output logic ack_oe
);
	localparam int PIN_W = 79;
	localparam logic [3:0] STROBE_LAST = 4'(`EBPS_STROBE_LAST);

	ebps_pkg::ebps_mst_t mst_q;
	ebps_pkg::ebps_slv_st_t slv_q;
	ebps_pkg::ebps_req_t cur_q;
	logic [3:0] cnt_q;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_st;
	logic [23:0] addr_st;
	logic [47:0] data_st;
	logic [3:0] sel_st;
	logic rd_n_st;
	logic wr_n_st;
	logic ack_st;
	logic full_lanes;
	logic slv_hit;

	// =====================================================
	// Decode
	// Active-low select of the bank that holds an address
	function automatic logic [3:0] bank_decode(
		input logic [27:0] a,
		input logic sdram
	);
		logic [1:0] b;
		b = sdram ? a[`EBPS_BANK_LSB_SDRAM +: 2] :
			a[`EBPS_BANK_LSB_PLAIN +: 2];
		bank_decode = ~(4'h1 << b);
	endfunction

	// Address falls in the peer register window
	function automatic logic in_iop(input logic [23:0] a);
		in_iop = (a < `EBPS_IOP_SPAN);
	endfunction

	// =====================================================
	// Pin inputs
	assign pin_raw = {ext_address_bus_i, ext_data_bus_i, bank_select_n_i,
		rd_n_i, wr_n_i, ack_i};

	// Strobes idle high so no false access is seen out of reset
	ebps_pin_sync #(
		.W(PIN_W),
		.INIT({24'h000000, 48'h000000000000, 4'hF, 1'b1, 1'b1, 1'b1})
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin(pin_raw),
		.stable(pin_st)
	);

	assign {addr_st, data_st, sel_st, rd_n_st, wr_n_st, ack_st} = pin_st;

	// Except for slave writes, mid and low lanes carry data only while both link ports are idle
	assign full_lanes = link_ports_off;

	// Outside register access: address taken as input when not master
	assign slv_hit = !bus_master && in_iop(addr_st);

	// =====================================================
	// Master sequence
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mst_q <= ebps_pkg::M_IDLE;
			cur_q <= '0;
			cnt_q <= 4'h0;
		end else begin
			unique case (mst_q)
				ebps_pkg::M_IDLE: begin
					// Peer access outside its register window is refused
					if (req_valid && req_ready &&
						!(req.peer && !in_iop(req.addr[23:0]))) begin
						cur_q <= req;
						cnt_q <= STROBE_LAST;
						mst_q <= ebps_pkg::M_STROBE;
					end
				end
				ebps_pkg::M_STROBE: begin
					if (cnt_q == 4'h0) begin
						mst_q <= ebps_pkg::M_WAIT;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ebps_pkg::M_WAIT: begin
					// Low acknowledge from outside stretches the access
					if (ack_st) begin
						mst_q <= cur_q.sync ? ebps_pkg::M_HOLD :
							ebps_pkg::M_IDLE;
					end
				end
				ebps_pkg::M_HOLD: begin
					mst_q <= ebps_pkg::M_IDLE;
				end
			endcase
		end
	end

	// Ready only while idle, master and no outside access is running
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= bus_master && slv_q == ebps_pkg::S_IDLE &&
				(mst_q == ebps_pkg::M_IDLE ? !req_valid : 
				(mst_q == ebps_pkg::M_HOLD ||
				(mst_q == ebps_pkg::M_WAIT && ack_st && !cur_q.sync)));
		end
	end

	// Refusal and completion pulses to the core
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_refused <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 48'h000000000000;
		end else begin
			req_refused <= mst_q == ebps_pkg::M_IDLE && req_valid &&
				req_ready && req.peer && !in_iop(req.addr[23:0]);
			rsp_valid <= mst_q == ebps_pkg::M_WAIT && ack_st;
			if (mst_q == ebps_pkg::M_WAIT && ack_st && !cur_q.write) begin
				rsp_rdata[47:16] <= data_st[47:16];
				// Whole 48-bit word only with link ports off, and for fetches only in unpacked full-width mode
				if (full_lanes && (!cur_q.fetch ||
					instr_pack_field == `EBPS_PACK_FULL)) begin
					rsp_rdata[15:0] <= data_st[15:0];
				end else begin
					rsp_rdata[15:0] <= 16'h0000;
				end
			end
		end
	end

	// =====================================================
	// Address and select pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_address_bus_o <= 24'h000000;
			ext_address_bus_oe <= 1'b0;
			bank_select_n_o <= `EBPS_SEL_IDLE;
			bank_select_n_oe <= 1'b0;
		end else if (mst_q == ebps_pkg::M_IDLE && req_valid && req_ready &&
			!(req.peer && !in_iop(req.addr[23:0]))) begin
			ext_address_bus_o <= req.addr[23:0];
			ext_address_bus_oe <= 1'b1;
			// Select comes out with the address in either mode
			bank_select_n_o <= req.peer ? `EBPS_SEL_IDLE :
				bank_decode(req.addr, req.sdram);
			bank_select_n_oe <= 1'b1;
		end else if (mst_q == ebps_pkg::M_WAIT && ack_st) begin
			bank_select_n_o <= `EBPS_SEL_IDLE;
			if (!cur_q.sync) begin
				// Asynchronous: address and select let go together
				ext_address_bus_oe <= 1'b0;
				bank_select_n_oe <= 1'b0;
			end
		end else if (mst_q == ebps_pkg::M_HOLD) begin
			// Synchronous: address outlives the select by one cycle
			ext_address_bus_oe <= 1'b0;
			bank_select_n_oe <= 1'b0;
		end
	end

	// =====================================================
	// Strobes: only the master drives them, never both low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			rd_n_oe <= 1'b0;
			wr_n_oe <= 1'b0;
		end else if (mst_q == ebps_pkg::M_IDLE && req_valid && req_ready &&
			!(req.peer && !in_iop(req.addr[23:0]))) begin
			rd_n_o <= req.write;
			wr_n_o <= !req.write;
			rd_n_oe <= 1'b1;
			wr_n_oe <= 1'b1;
		end else if (mst_q == ebps_pkg::M_WAIT && ack_st) begin
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
		end else if (mst_q == ebps_pkg::M_IDLE || !bus_master) begin
			// Strobes parked high, then released to the next master
			rd_n_oe <= 1'b0;
			wr_n_oe <= 1'b0;
		end
	end

	// =====================================================
	// Slave sequence for outside register access
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slv_q <= ebps_pkg::S_IDLE;
			slv_valid <= 1'b0;
			slv_conflict <= 1'b0;
			slv_req <= '0;
		end else begin
			slv_valid <= 1'b0;
			slv_conflict <= 1'b0;
			unique case (slv_q)
				ebps_pkg::S_IDLE: begin
					if (slv_hit && !rd_n_st && !wr_n_st) begin
						slv_conflict <= 1'b1;
					end else if (slv_hit && (!rd_n_st || !wr_n_st)) begin
						slv_valid <= 1'b1;
						slv_req.write <= !wr_n_st;
						slv_req.addr <= addr_st;
						slv_req.wdata <= data_st;
						slv_q <= ebps_pkg::S_BUSY;
					end
				end
				ebps_pkg::S_BUSY: begin
					if (slv_done) begin
						slv_q <= ebps_pkg::S_END;
					end
				end
				ebps_pkg::S_END: begin
					// Wait for the strobe to rise so one access counts once
					if (rd_n_st && wr_n_st) begin
						slv_q <= ebps_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

	// Acknowledge held low until the register access is done
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_o <= 1'b1;
			ack_oe <= 1'b0;
		end else if (slv_q == ebps_pkg::S_IDLE && slv_hit &&
			(rd_n_st != wr_n_st)) begin
			ack_o <= 1'b0;
			ack_oe <= 1'b1;
		end else if (slv_q == ebps_pkg::S_BUSY && slv_done) begin
			ack_o <= 1'b1;
		end else if (slv_q == ebps_pkg::S_END && rd_n_st && wr_n_st) begin
			ack_oe <= 1'b0;
		end
	end

	// Selects of the current master are watched while we are slave
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_seen <= 4'h0;
		end else begin
			bank_seen <= bus_master ? 4'h0 : ~sel_st;
		end
	end

	// =====================================================
	// Data pins, shared by master writes and slave reads
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_data_bus_o <= 48'h000000000000;
			ext_data_bus_upper_oe <= 1'b0;
			ext_data_bus_mid_oe <= 1'b0;
			ext_data_bus_low_oe <= 1'b0;
		end else if (mst_q == ebps_pkg::M_IDLE && req_valid && req_ready &&
			req.write && !(req.peer && !in_iop(req.addr[23:0]))) begin
			ext_data_bus_o <= req.wdata;
			ext_data_bus_upper_oe <= 1'b1;
			ext_data_bus_mid_oe <= full_lanes;
			ext_data_bus_low_oe <= full_lanes;
		end else if (slv_q == ebps_pkg::S_BUSY && slv_done &&
			!slv_req.write) begin
			ext_data_bus_o <= slv_rdata;
			ext_data_bus_upper_oe <= 1'b1;
			ext_data_bus_mid_oe <= full_lanes;
			ext_data_bus_low_oe <= full_lanes;
		end else if ((mst_q == ebps_pkg::M_WAIT && ack_st) ||
			(slv_q == ebps_pkg::S_END && rd_n_st && wr_n_st)) begin
			ext_data_bus_upper_oe <= 1'b0;
			ext_data_bus_mid_oe <= 1'b0;
			ext_data_bus_low_oe <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/ebps_port_checker.sv */
// Assertions on the external bus port pins
`timescale 1ns/10ps
`default_nettype none
module ebps_port_checker (
	// Core side
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire ebps_pkg::ebps_req_t req,
	input wire logic req_ready,
	input wire logic req_refused,
	input wire logic rsp_valid,
	// Slave side
	input wire logic bus_master,
	input wire logic link_ports_off,
	input wire logic slv_valid,
	input wire logic ack_o,
	input wire logic ack_oe,
	// Pins
	input wire logic [23:0] ext_address_bus_o,
	input wire logic ext_address_bus_oe,
	input wire logic ext_data_bus_upper_oe,
	input wire logic ext_data_bus_mid_oe,
	input wire logic ext_data_bus_low_oe,
	input wire logic [3:0] bank_select_n_o,
	input wire logic rd_n_o,
	input wire logic rd_n_oe,
	input wire logic wr_n_o,
	input wire logic wr_n_oe
);
	// ==========
	// Decode and mode of the access in flight
	logic bad;
	logic sync_q;
	logic [1:0] bk;
	assign bad = req.peer && req.addr[23:0] >= 24'h000200;
	assign bk = req.sdram ? req.addr[27:26] : req.addr[25:24];
	// Sync accesses keep the address one cycle past the end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_q <= 1'b0;
		end else if (req_valid && req_ready) begin
			sync_q <= req.sync;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_take;
		req_valid && req_ready && !bad;
	endsequence
	property p_rw_excl;
		rd_n_oe && wr_n_oe |-> rd_n_o || wr_n_o;
	endproperty
	a_rw_excl: assert property (p_rw_excl)
		else $error("both strobes low");
	property p_rd;
		s_take ##0 !req.write |=> rd_n_oe && !rd_n_o;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read strobe missing");
	property p_wr;
		s_take ##0 req.write |=> !wr_n_o && ext_data_bus_upper_oe;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write strobe or data missing");
	property p_lanes;
		s_take ##0 req.write |=>
			ext_data_bus_mid_oe == $past(link_ports_off) &&
			ext_data_bus_low_oe == $past(link_ports_off);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("mid or low data lanes driven wrongly");
	property p_addr;
		s_take |=> ext_address_bus_oe &&
			ext_address_bus_o == $past(req.addr[23:0]);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address pins wrong");
	property p_bank;
		s_take |=> bank_select_n_o ==
			($past(req.peer) ? 4'hF : ~(4'h1 << $past(bk)));
	endproperty
	a_bank: assert property (p_bank)
		else $error("bank select wrong");
	property p_refuse;
		req_valid && req_ready && bad |=> req_refused && rd_n_o && wr_n_o;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("peer request outside window not refused");
	property p_end;
		rsp_valid |-> bank_select_n_o == 4'hF &&
			ext_address_bus_oe == sync_q;
	endproperty
	a_end: assert property (p_end)
		else $error("select or address wrong at access end");
	property p_sync_off;
		rsp_valid && sync_q |=> !ext_address_bus_oe;
	endproperty
	a_sync_off: assert property (p_sync_off)
		else $error("address held too long");
	property p_ack;
		slv_valid |-> ack_oe && !ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("no wait state on register access");
	property p_slave;
		!bus_master [*2] |-> !ext_address_bus_oe && !rd_n_oe && !wr_n_oe;
	endproperty
	a_slave: assert property (p_slave)
		else $error("slave drives address or strobes");
endmodule
bind ebps_port ebps_port_checker u_chk (.ref_clk, .rst, .req_valid, .req,
	.req_ready, .req_refused, .rsp_valid, .bus_master, .link_ports_off,
	.slv_valid, .ack_o, .ack_oe, .ext_address_bus_o, .ext_address_bus_oe,
	.ext_data_bus_upper_oe, .ext_data_bus_mid_oe, .ext_data_bus_low_oe,
	.bank_select_n_o, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe);
`default_nettype wire

/* File: testbench/ebps_mem_model.sv */
// Memory and peripheral model on the far side of the external bus
`timescale 1ns/10ps
`default_nettype none
module ebps_mem_model (
	// Clock and mode
	input wire logic ref_clk,
	input wire logic active,
	input wire logic slow,
	// Bus pins as seen on the board
	input wire logic [23:0] addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [47:0] d_in,
	output logic [47:0] d_out,
	output logic ack
);
	// ==========
	// Storage and wait counter
	logic [47:0] mem [16];
	logic [47:0] last_q = 48'h000000000000;
	logic [2:0] cnt_q;
	logic strb;
	assign strb = active && !(rd_n && wr_n);
	// Wait states count from strobe assertion
	always_ff @(posedge ref_clk) begin
		if (!strb) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h7) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	// Pulled-up line: idles high, slow target holds it low a while
	assign ack = !strb || !slow || cnt_q >= 3'h6;
	// Strobes are only watched, never driven here
	always_ff @(posedge ref_clk) begin
		if (active && !wr_n) begin
			mem[addr[3:0]] <= d_in;
		end
		if (active && !rd_n) begin
			last_q <= mem[addr[3:0]];
		end
	end
	// Released lines show the inverse of the last word read
	assign d_out = (active && !rd_n) ? mem[addr[3:0]] : ~last_q;
endmodule
`default_nettype wire

/* File: testbench/external_bus_port_strobes_bench.sv */
// Self-checking bench of the external bus port block
`timescale 1ns/10ps
`default_nettype none
module external_bus_port_strobes_bench;
	// ==========
	// Stimulus, set at time zero
	logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, lk_off = 1'b1;
	logic bus_master = 1'b1, slv_done = 1'b0, slow = 1'b0, h_rd = 1'b1;
	logic h_wr = 1'b1;
	logic [1:0] pack = 2'h1;
	logic [3:0] h_sel = 4'hF;
	logic [47:0] slv_rdata = 48'h0, h_d = 48'h0;
	ebps_pkg::ebps_req_t req = '0;
	int miscompares = 0, num_checks = 0;
	// Observed side
	logic req_ready, req_refused, rsp_valid, slv_valid, refd, rd, wr, conf;
	logic a_oe, u_oe, s_oe, rd_o, rd_oe, wr_o, wr_oe, ack_o, ack_oe, m_ack;
	logic [3:0] bank_seen, sel_o, sel;
	logic [5:0] watch;
	logic [23:0] a_o, adr;
	logic [47:0] rsp_rdata, d_o, m_d, d_i, rdat;
	ebps_pkg::ebps_slv_t slv_req;
	// Board wiring: a pin shows its driver, else the far side
	assign rd = rd_oe ? rd_o : h_rd;
	assign wr = wr_oe ? wr_o : h_wr;
	assign adr = a_oe ? a_o : 24'h000040;
	assign sel = s_oe ? sel_o : h_sel;
	assign d_i = u_oe ? d_o : (bus_master ? m_d : h_d);
	assign watch = {conf, ack_oe, ack_o && ack_oe, slv_valid,
		rsp_valid || req_refused, req_ready};
	ebps_port dut (.ref_clk, .rst, .req_valid, .req, .req_ready, .req_refused,
		.rsp_valid, .rsp_rdata, .instr_pack_field(pack),
		.link_ports_off(lk_off), .bus_master, .slv_valid, .slv_req,
		.slv_done, .slv_rdata, .slv_conflict(conf), .bank_seen,
		.ext_address_bus_i(adr), .ext_address_bus_o(a_o),
		.ext_address_bus_oe(a_oe), .ext_data_bus_i(d_i),
		.ext_data_bus_o(d_o), .ext_data_bus_upper_oe(u_oe),
		.ext_data_bus_mid_oe(), .ext_data_bus_low_oe(),
		.bank_select_n_i(sel), .bank_select_n_o(sel_o),
		.bank_select_n_oe(s_oe), .rd_n_i(rd), .rd_n_o(rd_o), .rd_n_oe(rd_oe),
		.wr_n_i(wr), .wr_n_o(wr_o), .wr_n_oe(wr_oe),
		.ack_i(ack_oe ? ack_o : m_ack), .ack_o, .ack_oe);
	ebps_mem_model far (.ref_clk, .active(bus_master), .slow, .addr(adr),
		.rd_n(rd), .wr_n(wr), .d_in(d_i), .d_out(m_d), .ack(m_ack));
	// Clock
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk_val(input logic [47:0] g, input logic [47:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Bounded wait on one watched condition
	task automatic wait_on(input int k, input logic v);
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (watch[k] === v) return;
		end
		miscompares++;
		final_report();
	endtask
	// One core access, held until taken, then its end or refusal
	task automatic mreq(input logic [4:0] fl, input logic [27:0] a,
		input logic [47:0] wd);
		@(posedge ref_clk);
		req <= {fl, a, wd};
		req_valid <= 1'b1;
		wait_on(0, 1'b1);
		req_valid <= 1'b0;
		wait_on(1, 1'b1);
		rdat = rsp_rdata;
		refd = req_refused;
	endtask
	// Banks 1 and 3 in both decodes, sync and async, back to back
	task automatic t_banks();
		for (int b = 0; b < 8; b++) begin
			mreq({~b[2], 2'b00, 2'(b)}, {2'(b), 2'(3 - b), 22'h000000, 2'(b)},
				{12'(b), 36'hC0FFEE123});
			if (b > 3) chk_val(rdat, {12'(b - 4), 36'hC0FFEE123});
		end
	endtask
	// Low lanes carry data only with link ports off and, for fetches, full-width packing
	task automatic t_lanes();
		logic [19:0] tb = 20'h18CDE;
		logic [3:0] c;
		logic [47:0] e;
		mreq(5'b10000, 28'h0000007, 48'h13579BDF2468);
		for (int i = 0; i < 5; i++) begin
			c = tb[i * 4 +: 4];
			lk_off <= c[3];
			pack <= c[1:0];
			mreq({1'b0, c[2], 3'b000}, 28'h0000007, 48'h0);
			e = 48'h13579BDF2468;
			if (!c[3] || (c[2] && c[1:0] != 2'h1)) e[15:0] = 16'h0000;
			chk_val(rdat, e);
		end
		// Write with link ports in use: only the upper lanes are driven
		mreq(5'b10000, 28'h0000008, 48'h2468ACE13579);
		lk_off <= 1'b1;
		pack <= 2'h1;
	endtask
	// Peer window edge with a slow target, then just past it
	task automatic t_peer();
		slow <= 1'b1;
		mreq(5'b10100, 28'h00001FF, 48'hABCDEF012345);
		mreq(5'b00110, 28'h00001FF, 48'h0);
		chk_val(rdat, 48'hABCDEF012345);
		mreq(5'b00100, 28'h0000200, 48'h0);
		chk_val({47'h0, refd}, 48'h1);
		slow <= 1'b0;
	endtask
	// Outside master writes then reads one of our registers
	task automatic t_slave();
		bus_master <= 1'b0;
		h_sel <= 4'hB;
		repeat (6) @(posedge ref_clk);
		chk_val({44'h0, bank_seen}, 48'h4);
		h_d <= 48'h0F1E2D3C4B5A;
		h_wr <= 1'b0;
		wait_on(2, 1'b1);
		chk_val({23'h0, slv_req.write, slv_req.addr}, 48'h1000040);
		chk_val(slv_req.wdata, 48'h0F1E2D3C4B5A);
		slv_done <= 1'b1;
		@(posedge ref_clk);
		slv_done <= 1'b0;
		wait_on(3, 1'b1);
		h_wr <= 1'b1;
		wait_on(4, 1'b0);
		h_rd <= 1'b0;
		wait_on(2, 1'b1);
		chk_val({23'h0, slv_req.write, slv_req.addr}, 48'h40);
		slv_rdata <= 48'h5A5A00C3C3FF;
		slv_done <= 1'b1;
		@(posedge ref_clk);
		slv_done <= 1'b0;
		wait_on(3, 1'b1);
		@(posedge ref_clk);
		chk_val(u_oe ? d_o : 48'h0, 48'h5A5A00C3C3FF);
		h_rd <= 1'b1;
		wait_on(4, 1'b0);
		// Both strobes low together: flagged, neither served nor stretched
		h_rd <= 1'b0;
		h_wr <= 1'b0;
		wait_on(5, 1'b1);
		chk_val({46'h0, ack_oe, slv_valid}, 48'h0);
		h_rd <= 1'b1;
		h_wr <= 1'b1;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_banks();
		t_lanes();
		t_peer();
		t_slave();
		final_report();
	end
endmodule
`default_nettype wire
